/* dis_chk.sv */
// port-level assertions for the integrator sequencer
`timescale 1ns/1ns
module dis_chk (
  input wire logic        sys_clk,            // clock
  input wire logic        rst,                // reset
  input wire logic        dev_reset_n,        // device reset
  input wire logic        integrate_toggle,   // toggle pin
  input wire logic        serial_data_clock,  // serial clock
  input wire logic        psel,               // apb select
  input wire logic        penable,            // apb enable
  input wire logic        pwrite,             // apb write
  input wire logic [11:0] paddr,              // apb address
  input wire logic [31:0] pwdata,             // apb data
  input wire logic        pready,             // apb ready
  input wire logic        result_ready_n,     // ready, low
  input wire logic        inputs_ground,      // grounded
  input wire logic        integrate_a,        // side A
  input wire logic        integrate_b,        // side B
  input wire logic        speed_power_select  // speed
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst || !dev_reset_n);
  logic seen_q;
  logic last_b_q;
  // ready window after a side swap, counted here since it is too long for a delay range
  localparam logic [11:0] LATE_LO  = dis_pkg::CONT_DRDY_TICKS - 12'h00a;
  localparam logic [11:0] LATE_HI  = dis_pkg::CONT_DRDY_TICKS + 12'h00a;
  localparam logic [11:0] LATE_END = dis_pkg::CONT_DRDY_TICKS + 12'h00b;
  logic [11:0] late_cnt_q;
  logic        late_hit_q;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      late_cnt_q <= 12'h000;
      late_hit_q <= 1'b0;
    end
    else if (!dev_reset_n)
    begin
      late_cnt_q <= 12'h000;
      late_hit_q <= 1'b0;
    end
    else if ($changed({integrate_a, integrate_b}) && !$past(inputs_ground) && !inputs_ground)
    begin
      late_cnt_q <= 12'h001;
      late_hit_q <= 1'b0;
    end
    else if (late_cnt_q != 12'h000)
    begin
      late_cnt_q <= (late_cnt_q == LATE_END) ? 12'h000 : 12'(late_cnt_q + 12'h001);
      if (late_cnt_q >= LATE_LO && late_cnt_q <= LATE_HI && !result_ready_n)
        late_hit_q <= 1'b1;
    end
  end
  // side of the last integration started, for the alternation check
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      seen_q   <= 1'b0;
      last_b_q <= 1'b0;
    end
    else if (!dev_reset_n)
      seen_q <= 1'b0;
    else if ($rose(integrate_a) || $rose(integrate_b))
    begin
      seen_q   <= 1'b1;
      last_b_q <= integrate_b;
    end
  end
  a_ground_idle: assert property (inputs_ground == !(integrate_a || integrate_b))
    else $error("ground flag disagrees with integration");
  a_one_side: assert property (!(integrate_a && integrate_b))
    else $error("both sides integrating");
  a_side_alt: assert property (($rose(integrate_a) || $rose(integrate_b)) && seen_q
    |-> last_b_q == integrate_a) else $error("same side integrated twice");
  a_level_hold: assert property (((integrate_a || integrate_b)
    && $stable(integrate_toggle)) [*8] |=> $stable({integrate_a, integrate_b}))
    else $error("state moved without toggle change");
  a_ready_hold: assert property ((!result_ready_n && !serial_data_clock) [*5]
    |=> !result_ready_n) else $error("ready cleared without serial clock");
  a_ready_late: assert property (late_cnt_q == LATE_END |-> late_hit_q)
    else $error("ready late after side swap");
  a_speed_copy: assert property (psel && penable && pready && pwrite
    && paddr == dis_pkg::CTRL_OFFS |-> ##2 speed_power_select == $past(pwdata[0], 2))
    else $error("speed select not taken");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  cover property ($fell(result_ready_n));
  cover property ($rose(inputs_ground) && $past(integrate_a || integrate_b));
  cover property ($fell(integrate_a) && $rose(integrate_b));
endmodule

bind dis_sequencer dis_chk u_chk (.sys_clk, .rst, .dev_reset_n, .integrate_toggle,
  .serial_data_clock, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .result_ready_n, .inputs_ground, .integrate_a, .integrate_b, .speed_power_select);

/* dis_host.sv */
// host model: drives the integrate toggle and fetches results
`timescale 1ns/1ns
module dis_host (
  input  wire logic        sys_clk,            // clock
  input  wire logic        run,                // toggling on
  input  wire logic        idle_lvl,           // toggle level when stopped
  input  wire logic [15:0] tint,               // integration period, cycles
  input  wire logic [7:0]  rd_delay,           // read latency, cycles
  input  wire logic        result_ready_n,     // ready from device
  output logic             integrate_toggle,   // toggle pin
  output logic             serial_data_clock,  // serial clock pin
  output logic [15:0]      reads               // results fetched
);
  logic [15:0] tcnt;
  logic [7:0]  rcnt;
  initial
  begin
    integrate_toggle  = 1'b0;
    serial_data_clock = 1'b0;
    reads             = 16'h0000;
    tcnt              = 16'h0000;
    rcnt              = 8'h00;
  end
  always @(posedge sys_clk)
  begin
    tcnt <= tcnt + 16'h0001;
    if (!run)
    begin
      integrate_toggle <= idle_lvl;
      tcnt             <= 16'h0000;
    end
    else if (tcnt >= tint - 16'h0001)
    begin
      integrate_toggle <= !integrate_toggle;
      tcnt             <= 16'h0000;
    end
    // a read starts only once ready is seen low
    if (rcnt != 8'h00 || !result_ready_n)
      rcnt <= rcnt + 8'h01;
    serial_data_clock <= (rcnt > rd_delay) && (rcnt <= rd_delay + 8'h04);
    if (rcnt == rd_delay + 8'h04)
      reads <= reads + 16'h0001;
    // hold-off lets the synchronised clear land before looking again
    if (rcnt == rd_delay + 8'h10)
      rcnt <= 8'h00;
  end
endmodule

/* dis_pkg.sv */
// shared constants, state codes and carrier types for the integrator sequencer
package dis_pkg;

  // apb register map
  localparam int          ADDR_W       = 12;
  localparam logic [11:0] CTRL_OFFS    = 12'h000;
  localparam logic [11:0] STATUS_OFFS  = 12'h004;

  // control register fields
  localparam int CTRL_SPEED_BIT = 0;
  localparam int CTRL_PRESC_BIT = 1;
  localparam logic CTRL_SPEED_RST = 1'b0;
  localparam logic CTRL_PRESC_RST = 1'b0;

  // status register fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_BUSY_BIT  = 4;
  localparam int STAT_READY_BIT = 5;
  localparam int STAT_GAP_BIT   = 6;
  localparam int STAT_PREP_BIT  = 7;

  // timing in internal clock periods
  localparam int CNT_W = 12;
  localparam logic [11:0] CONT_MRAZ_TICKS   = 12'd1470;
  localparam logic [11:0] CONT_DRDY_TICKS   = 12'd1380;
  localparam logic [11:0] NCONT_MRAZ_TICKS  = 12'd2901;
  localparam logic [11:0] NCONT_DRDY2_TICKS = 12'd1450;
  localparam logic [11:0] NCONT_SIDE2_TICKS = NCONT_MRAZ_TICKS - CONT_MRAZ_TICKS;
  localparam logic [11:0] PREP_TICKS        = 12'd72;

  // prescaler divides the system clock by four when selected
  localparam logic [1:0] PRESC_LAST = 2'h3;

  typedef enum logic [2:0] {
    DIS_S1 = 3'b000,
    DIS_S2 = 3'b001,
    DIS_S3 = 3'b010,
    DIS_S4 = 3'b011,
    DIS_S5 = 3'b100,
    DIS_S6 = 3'b101,
    DIS_S7 = 3'b110,
    DIS_S8 = 3'b111
  } dis_state_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } dis_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } dis_apb_rsp_t;

  typedef struct packed {
    logic ground;
    logic int_a;
    logic int_b;
    logic speed;
  } dis_front_t;

  typedef struct packed {
    dis_state_t   state;
    logic         init;
    logic         lvl;
    logic         tog;
    logic         pend;
    logic         two;
    logic [11:0]  meas;
    logic [11:0]  prep;
    logic [11:0]  rdy;
    logic [1:0]   div;
    logic         rdy_n;
    logic         serial_data_clock_prev;
    logic         ctl_speed;
    logic         ctl_presc;
    dis_apb_rsp_t apb;
    dis_front_t   fe;
  } dis_regs_t;

  localparam dis_regs_t DIS_RST = '{
    state:     DIS_S8,
    init:      1'b1,
    lvl:       1'b0,
    tog:       1'b0,
    pend:      1'b0,
    two:       1'b0,
    meas:      12'h000,
    prep:      12'h000,
    rdy:       12'h000,
    div:       2'h0,
    rdy_n:     1'b1,
    serial_data_clock_prev: 1'b0,
    ctl_speed: CTRL_SPEED_RST,
    ctl_presc: CTRL_PRESC_RST,
    apb:       '{pready: 1'b0, prdata: 32'h0000_0000, pslverr: 1'b0},
    fe:        '{ground: 1'b1, int_a: 1'b0, int_b: 1'b0, speed: CTRL_SPEED_RST}
  };

endpackage

/* dis_sequencer.sv */
// dual integrator sequencer: eight-state integrate/measure machine with apb control
// Function
// - speed select bit picks low power (0) or high speed (1) front end
// - result_ready_n goes low when a result is available; host reads after
// - ready timed from internal divided clock, one system clock phase uncertainty
// - reset pin low resets asynchronously; host holds it 50us, glitch free
// - each cycle digitizes one side of two integrators and resets them
// - continuous mode keeps one side always integrating
// - gapped mode suspends integration until digitizing catches up
// - states 3 to 6 integrate A, B/meas A, A/meas B, B
// - states 1 and 8 finish measuring; 2 and 7 prepare A and B
// - transitions use sampled toggle level together with measure busy
// - measure busy spans every measure/reset/autozero cycle, internal only
// - continuous mode: idle side ready, toggle alone picks next state
// - toggle change while busy enters or holds state 1 or 8
// - busy released in wait state moves to prepare state 2 or 7
// - current inputs grounded in every gapped state
// - integrations always alternate between side A and side B
// - start in state 1 if toggle high, state 8 if low
// - inverted toggle drives each state to its mirror partner
// - ready stays low until serial data clock goes high then low
// - continuous measure cycle lasts 1470 internal clock periods
// - continuous ready asserts 1380 periods after the toggle change
// - gapped two-side measure cycle lasts 2901 periods
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ns

module dis_sequencer (
  input  wire logic                       sys_clk,             // system clock, 50 MHz
  input  wire logic                       rst,                 // async reset, active high
  input  wire logic                       ce,                  // clock enable, freezes state
  input  wire logic                       dev_reset_n,         // device reset pin, active low
  input  wire logic                       integrate_toggle,    // integrate toggle pin
  input  wire logic                       serial_data_clock,   // serial data clock pin
  input  wire logic                       psel,                // apb select
  input  wire logic                       penable,             // apb enable
  input  wire logic                       pwrite,              // apb direction
  input  wire logic [dis_pkg::ADDR_W-1:0] paddr,               // apb byte address
  input  wire logic [31:0]                pwdata,              // apb write data
  output logic                            pready,              // apb ready
  output logic [31:0]                     prdata,              // apb read data
  output logic                            pslverr,             // apb error
  output logic                            result_ready_n,      // result ready, active low
  output logic                            inputs_ground,       // current inputs grounded
  output logic                            integrate_a,         // side A integrating
  output logic                            integrate_b,         // side B integrating
  output logic                            speed_power_select   // front end speed select
);

  dis_pkg::dis_regs_t    q;
  dis_pkg::dis_regs_t    d;
  dis_pkg::dis_apb_req_t req;
  logic [1:0]            rsync_q;
  logic [1:0]            tog_sync_q;
  logic [1:0]            serial_data_clock_sync_q;
  logic                  core_rst;
  logic                  tog_s;
  logic                  serial_data_clock_s;
  logic                  tick;
  logic                  busy;
  logic                  chg;
  logic                  prep_done;
  logic                  fire;
  logic                  gapped;
  logic                  rd_cyc;
  logic                  wr_done;

  // pin reset asserts at once, release is synchronised to avoid a ragged exit
  always_ff @(posedge sys_clk or negedge dev_reset_n)
  begin
    if (!dev_reset_n)
    begin
      rsync_q <= 2'h0;
    end
    else
    begin
      rsync_q <= {rsync_q[0], 1'b1};
    end
  end

  assign core_rst = rst | ~rsync_q[1];

  // two-stage synchronisers for the host pins
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      tog_sync_q  <= 2'h0;
      serial_data_clock_sync_q <= 2'h0;
    end
    else if (ce)
    begin
      tog_sync_q  <= {tog_sync_q[0], integrate_toggle};
      serial_data_clock_sync_q <= {serial_data_clock_sync_q[0], serial_data_clock};
    end
  end

  assign tog_s  = tog_sync_q[1];
  assign serial_data_clock_s = serial_data_clock_sync_q[1];

  always_comb
  begin
    req.psel    = psel;
    req.penable = penable;
    req.pwrite  = pwrite;
    req.paddr   = paddr;
    req.pwdata  = pwdata;
  end

  // internal clock enable: every cycle, or every fourth with prescaler on
  assign tick = q.ctl_presc ? (q.div == dis_pkg::PRESC_LAST) : 1'b1;

  assign busy      = (q.meas != 12'h000);
  assign prep_done = (q.prep == 12'h000);
  assign chg       = (q.tog != q.lvl);
  assign fire      = tick && (q.rdy == 12'h001);
  assign rd_cyc    = req.psel && req.penable && !q.apb.pready;
  assign wr_done   = req.psel && req.penable && q.apb.pready && req.pwrite;

  always_comb
  begin
    gapped = 1'b0;
    d      = q;

    // apb slave: answer one cycle into the access phase
    d.apb.pready = 1'b0;
    if (rd_cyc)
    begin
      d.apb.pready  = 1'b1;
      d.apb.pslverr = 1'b0;
      d.apb.prdata  = 32'h0000_0000;
      if (req.paddr == dis_pkg::CTRL_OFFS)
      begin
        d.apb.prdata[dis_pkg::CTRL_SPEED_BIT] = q.ctl_speed;
        d.apb.prdata[dis_pkg::CTRL_PRESC_BIT] = q.ctl_presc;
      end
      else if (req.paddr == dis_pkg::STATUS_OFFS)
      begin
        d.apb.prdata[dis_pkg::STAT_STATE_LSB +: 4] = 4'({1'b0, q.state} + 4'h1);
        d.apb.prdata[dis_pkg::STAT_BUSY_BIT]       = busy;
        d.apb.prdata[dis_pkg::STAT_READY_BIT]      = ~q.rdy_n;
        d.apb.prdata[dis_pkg::STAT_GAP_BIT]        = q.fe.ground;
        d.apb.prdata[dis_pkg::STAT_PREP_BIT]       = ~prep_done;
      end
      else
      begin
        d.apb.pslverr = 1'b1;
      end
    end
    if (wr_done && (req.paddr == dis_pkg::CTRL_OFFS))
    begin
      d.ctl_speed = req.pwdata[dis_pkg::CTRL_SPEED_BIT];
      d.ctl_presc = req.pwdata[dis_pkg::CTRL_PRESC_BIT];
    end

    // prescaler phase counter
    d.div = q.ctl_presc ? 2'(q.div + 2'h1) : 2'h0;

    // ready clears on a falling serial data clock after it was high
    d.serial_data_clock_prev = serial_data_clock_s;
    if (q.serial_data_clock_prev && !serial_data_clock_s)
    begin
      d.rdy_n = 1'b1;
    end

    if (tick)
    begin
      d.tog = tog_s;
      if (busy)
      begin
        d.meas = 12'(q.meas - 12'h001);
      end
      if (!prep_done)
      begin
        d.prep = 12'(q.prep - 12'h001);
      end
      if (q.rdy != 12'h000)
      begin
        d.rdy = 12'(q.rdy - 12'h001);
      end
      // a new result beats a clear in the same cycle
      if (fire)
      begin
        d.rdy_n = 1'b0;
        if (q.two)
        begin
          d.rdy = dis_pkg::NCONT_DRDY2_TICKS;
          d.two = 1'b0;
        end
      end

      if (q.init)
      begin
        d.init  = 1'b0;
        d.lvl   = tog_s;
        d.tog   = tog_s;
        d.state = tog_s ? dis_pkg::DIS_S1 : dis_pkg::DIS_S8;
      end
      else
      begin
        case (q.state)
          dis_pkg::DIS_S3:
          begin
            if (chg)
            begin
              d.lvl   = q.tog;
              d.state = dis_pkg::DIS_S4;
              d.meas  = dis_pkg::CONT_MRAZ_TICKS;
              d.rdy   = dis_pkg::CONT_DRDY_TICKS;
            end
          end
          dis_pkg::DIS_S6:
          begin
            if (chg)
            begin
              d.lvl   = q.tog;
              d.state = dis_pkg::DIS_S5;
              d.meas  = dis_pkg::CONT_MRAZ_TICKS;
              d.rdy   = dis_pkg::CONT_DRDY_TICKS;
            end
          end
          dis_pkg::DIS_S4:
          begin
            if (chg && !busy)
            begin
              d.lvl   = q.tog;
              d.state = dis_pkg::DIS_S5;
              d.meas  = dis_pkg::CONT_MRAZ_TICKS;
              d.rdy   = dis_pkg::CONT_DRDY_TICKS;
            end
            else if (chg)
            begin
              // side B ended integration before side A was measured
              d.lvl   = q.tog;
              d.state = dis_pkg::DIS_S1;
              d.pend  = 1'b1;
              d.two   = 1'b1;
            end
          end
          dis_pkg::DIS_S5:
          begin
            if (chg && !busy)
            begin
              d.lvl   = q.tog;
              d.state = dis_pkg::DIS_S4;
              d.meas  = dis_pkg::CONT_MRAZ_TICKS;
              d.rdy   = dis_pkg::CONT_DRDY_TICKS;
            end
            else if (chg)
            begin
              d.lvl   = q.tog;
              d.state = dis_pkg::DIS_S8;
              d.pend  = 1'b1;
              d.two   = 1'b1;
            end
          end
          dis_pkg::DIS_S1, dis_pkg::DIS_S8:
          begin
            // toggles while busy are absorbed: integration is suspended here
            if (chg)
            begin
              d.lvl = q.tog;
            end
            if (!busy && q.pend)
            begin
              d.pend = 1'b0;
              d.meas = dis_pkg::NCONT_SIDE2_TICKS;
            end
            else if (!busy)
            begin
              d.prep  = dis_pkg::PREP_TICKS;
              d.state = (q.state == dis_pkg::DIS_S1) ? dis_pkg::DIS_S2 :
                                                        dis_pkg::DIS_S7;
            end
          end
          dis_pkg::DIS_S2:
          begin
            if (chg && prep_done)
            begin
              d.lvl   = q.tog;
              d.state = dis_pkg::DIS_S3;
            end
          end
          dis_pkg::DIS_S7:
          begin
            if (chg && prep_done)
            begin
              d.lvl   = q.tog;
              d.state = dis_pkg::DIS_S6;
            end
          end
          default:
          begin
            d.state = dis_pkg::DIS_S8;
          end
        endcase
      end
    end

    // front end controls follow the next state so they change with it
    case (d.state)
      dis_pkg::DIS_S1, dis_pkg::DIS_S2, dis_pkg::DIS_S7, dis_pkg::DIS_S8:
      begin
        gapped = 1'b1;
      end
      default:
      begin
        gapped = 1'b0;
      end
    endcase
    d.fe.ground = gapped;
    d.fe.int_a  = (d.state == dis_pkg::DIS_S3) || (d.state == dis_pkg::DIS_S5);
    d.fe.int_b  = (d.state == dis_pkg::DIS_S4) || (d.state == dis_pkg::DIS_S6);
    d.fe.speed  = d.ctl_speed;
  end

  always_ff @(posedge sys_clk or posedge core_rst)
  begin
    if (core_rst)
    begin
      q <= dis_pkg::DIS_RST;
    end
    else if (ce)
    begin
      q <= d;
    end
  end

  assign pready             = q.apb.pready;
  assign prdata             = q.apb.prdata;
  assign pslverr            = q.apb.pslverr;
  assign result_ready_n     = q.rdy_n;
  assign inputs_ground      = q.fe.ground;
  assign integrate_a        = q.fe.int_a;
  assign integrate_b        = q.fe.int_b;
  assign speed_power_select = q.fe.speed;

endmodule

/* tb_top.sv */
// self-checking bench for the integrator sequencer
`timescale 1ns/1ns
module tb_top;
  logic        sys_clk = 1'b0, rst = 1'b1, dev_reset_n = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, lfsr_q = 32'h26cf_81c7;
  logic        pready, pslverr, err, result_ready_n, inputs_ground;
  logic        integrate_a, integrate_b, speed_power_select;
  logic        integrate_toggle, serial_data_clock, run = 1'b0, idle_lvl = 1'b0;
  logic [15:0] tint = 16'd1600, reads, r0;
  logic [7:0]  rd_delay = 8'h00;
  logic        count_en = 1'b0;
  int          gnd_cnt = 0, fail_count = 0, total_checks = 0;

  always #10 sys_clk = !sys_clk;

  dis_sequencer dut (.sys_clk, .rst, .ce(1'b1), .dev_reset_n, .integrate_toggle,
    .serial_data_clock, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .result_ready_n, .inputs_ground, .integrate_a, .integrate_b,
    .speed_power_select);
  dis_host host (.sys_clk, .run, .idle_lvl, .tint, .rd_delay, .result_ready_n,
    .integrate_toggle, .serial_data_clock, .reads);

  always @(posedge sys_clk)
    if (count_en && inputs_ground === 1'b1)
      gnd_cnt <= gnd_cnt + 1;

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic reads_ok(input logic [15:0] n, input int cyc, input int per);
    return (int'(n) >= cyc / per - 2) && (int'(n) <= cyc / per + 1);
  endfunction

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge sys_clk);
    end
    if (n == 50)
      fail_count++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic run_for(input logic [15:0] per, input int cyc);
    logic [15:0] rs;
    lfsr_q = lfsr_next(lfsr_q);
    rs = reads;
    tint     <= per;
    rd_delay <= {1'b0, lfsr_q[6:0]};
    run      <= 1'b1;
    repeat (4000) @(posedge sys_clk);
    // early results after a restart are not trusted
    while (16'(reads - rs) < 16'h0004)
      @(posedge sys_clk);
    r0 = reads;
    gnd_cnt  <= 0;
    count_en <= 1'b1;
    repeat (cyc) @(posedge sys_clk);
    count_en <= 1'b0;
  endtask

  initial
  begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    apb(1'b0, dis_pkg::CTRL_OFFS, 32'h0000_0000);
    chk("ctrl_reset", rd, {30'h0, dis_pkg::CTRL_PRESC_RST, dis_pkg::CTRL_SPEED_RST});
    repeat (4)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      apb(1'b1, dis_pkg::CTRL_OFFS, lfsr_q);
      apb(1'b0, dis_pkg::CTRL_OFFS, 32'h0000_0000);
      chk("ctrl", rd, lfsr_q & 32'h0000_0003);
      chk("speed", speed_power_select, lfsr_q[0]);
    end
    apb(1'b1, dis_pkg::CTRL_OFFS, 32'h0000_0000);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
    $display("test registers done");
    for (int l = 0; l < 2; l++)
    begin
      idle_lvl <= l[0];
      repeat (4) @(posedge sys_clk);
      dev_reset_n <= 1'b0;
      repeat (2500) @(posedge sys_clk);
      chk("reset_ready", result_ready_n, 1'b1);
      chk("reset_ground", inputs_ground, 1'b1);
      dev_reset_n <= 1'b1;
      // start state is picked on the first tick after the synchronised release
      repeat (4) @(posedge sys_clk);
      apb(1'b0, dis_pkg::STATUS_OFFS, 32'h0000_0000);
      chk("start", rd[3:0] == (l ? 4'h1 : 4'h8) || rd[3:0] == (l ? 4'h2 : 4'h7), 1);
    end
    $display("test power-up done");
    run_for(16'd1600, 16000);
    chk("cont_ground", gnd_cnt == 0, 1'b1);
    chk("cont_reads", reads_ok(reads - r0, 16000, 1600), 1'b1);
    $display("test continuous done");
    lfsr_q = lfsr_next(lfsr_q);
    run_for(16'd700 + {10'h000, lfsr_q[5:0]}, 12000);
    chk("gap_ground", gnd_cnt > 0, 1'b1);
    chk("gap_reads", reads - r0 > 0, 1'b1);
    $display("test gapped done");
    stop_test();
  end

  initial
  begin
    repeat (80000) @(posedge sys_clk);
    fail_count++;
    stop_test();
  end
endmodule
